// ===== servo_autotune_sequencer.sv
`include "servo_tune_params.svh"
`timescale 1ns/1ps
`default_nettype none

module servo_autotune_sequencer
  import servo_tune_pkg::*;
#(
  parameter int unsigned TUNE_CYCLES = `TUNE_CYCLES
) (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  // register bus
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             irq_out,
  // drive commands
  input  wire logic        enable_in,
  input  wire logic        ctrl_word_enable_in,
  input  wire logic        run_fwd_in,
  input  wire logic        run_reverse_command_in,
  // motor and encoder feedback
  input  wire logic        motor_stopped_in,
  input  wire logic        elec_rev_in,
  input  wire logic [15:0] encoder_angle_in,
  input  wire logic        trip_in,
  input  wire logic [15:0] headroom_volt_in,
  // power side and store
  output motor_cmd_s       motor_cmd_out,
  output nv_req_s          nv_req_out,
  output logic      [15:0] volt_limit_out,
  output logic      [7:0]  pole_count_out,
  output tune_state_e      drive_state_out,
  output logic      [15:0] current_loop_prop_gain_out,
  output logic      [15:0] current_loop_int_gain_out
);

  seq_state_s s_reg;
  seq_state_s s_next;
  logic       en_w;
  logic       run_w;
  logic       gains_ok_w;
  logic       tmo_w;
  logic       acc_w;
  logic       set_hit_w;
  logic [3:0] irq_set_w;
  logic [3:0] irq_clr_w;
  logic       testing_w;

  // enable needs all three sources, so any one of them removes it
  assign en_w       = enable_in & s_reg.sw_en & ctrl_word_enable_in;
  assign run_w      = run_fwd_in | run_reverse_command_in;
  assign gains_ok_w = (s_reg.res[s_reg.set2] != 16'h0000) && (s_reg.ind[s_reg.set2] != 16'h0000);
  assign tmo_w      = (s_reg.timer == 27'(TUNE_CYCLES - 1));
  assign acc_w      = (avs_read_in | avs_write_in) & ~s_reg.ack;
  assign set_hit_w  = ((avs_address_in & `AV_SET_MASK) == `AV_SET_BASE);
  assign testing_w  = (s_reg.fsm == ST_ALIGN) || (s_reg.fsm == ST_ROTATE) || (s_reg.fsm == ST_SETTLE);

  always_comb begin
    s_next      = s_reg;
    irq_set_w   = 4'h0;
    irq_clr_w   = 4'h0;
    s_next.ack  = acc_w;
    s_next.nv.save = 1'b0;
    s_next.nv.card = 1'b0;
    // background set-up values, refreshed every cycle
    s_next.volt_lim  = (s_reg.rated_v < headroom_volt_in) ? s_reg.rated_v : headroom_volt_in;
    s_next.eff_poles = (s_reg.poles == `POLES_AUTO) ? `POLES_AUTO_NUM : {s_reg.poles[6:0], 1'b0};
    // register writes land only in the answer cycle, when waitrequest is low
    if (s_reg.ack && avs_write_in) begin
      if (set_hit_w) begin
        case (avs_address_in[3:2])
          `SET_RES: s_next.res[avs_address_in[`AV_SET_BIT]] = avs_writedata_in[15:0];
          `SET_IND: s_next.ind[avs_address_in[`AV_SET_BIT]] = avs_writedata_in[15:0];
          `SET_ANGLE: s_next.angle[avs_address_in[`AV_SET_BIT]] = avs_writedata_in[15:0];
          default: begin
            s_next.pgain[avs_address_in[`AV_SET_BIT]] = avs_writedata_in[15:0];
            s_next.igain[avs_address_in[`AV_SET_BIT]] = avs_writedata_in[31:16];
          end
        endcase
      end else begin
        case (avs_address_in)
          `AV_CTRL: begin
            s_next.sw_en = avs_writedata_in[`CTRL_SW_EN];
            s_next.rev   = avs_writedata_in[`CTRL_REV];
            s_next.set2  = avs_writedata_in[`CTRL_SET2];
            s_next.card  = avs_writedata_in[`CTRL_CARD_HI:`CTRL_CARD_LO];
          end
          `AV_POLES: begin
            // out-of-range codes are dropped, not clipped
            if (avs_writedata_in[7:0] <= `POLES_MAX && avs_writedata_in[31:8] == 24'h00_0000) begin
              s_next.poles = avs_writedata_in[7:0];
            end
          end
          `AV_SELECT: begin
            if (avs_writedata_in[7:0] <= `SEL_GAINS && avs_writedata_in[31:8] == 24'h00_0000) begin
              s_next.sel = avs_writedata_in[7:0];
            end
          end
          `AV_IRQ_CLR: irq_clr_w = avs_writedata_in[3:0];
          `AV_IRQ_EN: s_next.irq_en = avs_writedata_in[3:0];
          `AV_RATED_V: s_next.rated_v = avs_writedata_in[15:0];
          default: ;
        endcase
      end
    end
    // register reads, unmapped words read zero
    if (acc_w && avs_read_in) begin
      s_next.rdata = 32'h0000_0000;
      if (set_hit_w) begin
        case (avs_address_in[3:2])
          `SET_RES: s_next.rdata[15:0] = s_reg.res[avs_address_in[`AV_SET_BIT]];
          `SET_IND: s_next.rdata[15:0] = s_reg.ind[avs_address_in[`AV_SET_BIT]];
          `SET_ANGLE: s_next.rdata[15:0] = s_reg.angle[avs_address_in[`AV_SET_BIT]];
          default: s_next.rdata = {s_reg.igain[avs_address_in[`AV_SET_BIT]], s_reg.pgain[avs_address_in[`AV_SET_BIT]]};
        endcase
      end else begin
        case (avs_address_in)
          `AV_CTRL: begin
            s_next.rdata[`CTRL_SW_EN] = s_reg.sw_en;
            s_next.rdata[`CTRL_REV]   = s_reg.rev;
            s_next.rdata[`CTRL_SET2]  = s_reg.set2;
            s_next.rdata[`CTRL_CARD_HI:`CTRL_CARD_LO] = s_reg.card;
          end
          `AV_POLES: s_next.rdata[7:0] = s_reg.poles;
          `AV_SELECT: s_next.rdata[7:0] = s_reg.sel;
          `AV_STATUS: s_next.rdata[15:0] = {s_reg.fsm, s_reg.lock, s_reg.act_set2, gains_ok_w, 1'b0, s_reg.eff_poles};
          `AV_IRQ_STAT: s_next.rdata[3:0] = s_reg.irq_stat;
          `AV_IRQ_EN: s_next.rdata[3:0] = s_reg.irq_en;
          `AV_RATED_V: s_next.rdata[15:0] = s_reg.rated_v;
          default: ;
        endcase
      end
    end
    // sequencer, one step per sampled level
    if (testing_w) begin
      s_next.timer = s_reg.timer + 27'h000_0001;
    end
    case (s_reg.fsm)
      ST_INHIBIT: begin
        if (!en_w) begin
          s_next.lock = 1'b0;
        end
        if (s_reg.sel == `SEL_GAINS) begin
          s_next.fsm = ST_GAINS;
        end else if (en_w && !s_reg.lock) begin
          if (run_w && s_reg.sel != `SEL_OFF) begin
            s_next.fsm      = ST_ALIGN;
            s_next.act_set2 = s_reg.set2;
            s_next.dir_rev  = s_reg.rev;
            s_next.timer    = 27'h000_0000;
            s_next.revs     = 2'h0;
          end else if (run_w) begin
            s_next.fsm = ST_RUN;
          end else if (s_reg.sel == `SEL_OFF) begin
            s_next.fsm = ST_STOP;
          end
        end
      end
      ST_STOP: begin
        if (s_reg.sel == `SEL_GAINS) begin
          s_next.fsm = ST_GAINS;
        end else if (!en_w) begin
          s_next.fsm = ST_INHIBIT;
        end else if (run_w && s_reg.sel == `SEL_OFF) begin
          s_next.fsm = ST_RUN;
        end else if (run_w) begin
          irq_set_w[`IRQ_REFUSED] = 1'b1;
        end
      end
      ST_RUN: begin
        if (!en_w || (!run_w && s_reg.sel != `SEL_OFF)) begin
          s_next.fsm = ST_INHIBIT;
        end else if (!run_w) begin
          s_next.fsm = ST_STOP;
        end
      end
      ST_ALIGN: begin
        // the rotor may snap up to half a revolution while it aligns
        if (motor_stopped_in) begin
          s_next.fsm = ST_ROTATE;
        end
      end
      ST_ROTATE: begin
        if (elec_rev_in) begin
          s_next.revs = s_reg.revs + 2'h1;
          if (s_reg.revs == `TUNE_REVS_LAST) begin
            s_next.fsm = ST_SETTLE;
          end
        end
      end
      ST_SETTLE: begin
        // capture only at rest, a moving rotor gives a skewed angle
        if (motor_stopped_in) begin
          s_next.angle[s_reg.act_set2] = encoder_angle_in;
          s_next.nv.save = 1'b1;
          s_next.nv.card = (s_reg.card == `CARD_AUTO) || (s_reg.card == `CARD_BOOT);
          s_next.nv.set2 = s_reg.act_set2;
          s_next.nv.item = `NV_ITEM_ANGLE;
          s_next.nv.data = {16'h0000, encoder_angle_in};
          s_next.sel     = `SEL_OFF;
          s_next.lock    = 1'b1;
          s_next.fsm     = ST_INHIBIT;
          irq_set_w[`IRQ_DONE] = 1'b1;
        end
      end
      ST_GAINS: begin
        if (gains_ok_w) begin
          s_next.pgain[s_reg.set2] = s_reg.ind[s_reg.set2];
          s_next.igain[s_reg.set2] = s_reg.res[s_reg.set2];
        end else begin
          irq_set_w[`IRQ_GAIN_BLK] = 1'b1;
        end
        s_next.sel = `SEL_OFF;
        s_next.fsm = ST_INHIBIT;
      end
      ST_TRIP: begin
        s_next.sel = `SEL_OFF;
        if (!en_w) begin
          s_next.fsm = ST_INHIBIT;
        end
      end
      default: s_next.fsm = ST_INHIBIT;
    endcase
    // a trip or overrun aborts the sequence before the store request goes out, though a settle capture still updates the angle register
    if (testing_w && (trip_in || tmo_w)) begin
      s_next.fsm     = ST_TRIP;
      s_next.nv.save = 1'b0;
      s_next.nv.card = 1'b0;
      s_next.sel     = s_reg.sel;
      s_next.lock    = 1'b0;
      irq_set_w      = 4'h0;
      irq_set_w[`IRQ_FAIL] = 1'b1;
    end
    s_next.cmd.energize = (s_next.fsm == ST_ALIGN) || (s_next.fsm == ST_ROTATE) || (s_next.fsm == ST_SETTLE);
    s_next.cmd.rotate   = (s_next.fsm == ST_ROTATE);
    s_next.cmd.reverse  = s_next.dir_rev;
    // a new event beats a clear in the same cycle
    s_next.irq_stat = (s_reg.irq_stat & ~irq_clr_w) | irq_set_w;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      s_reg           <= '0;
      s_reg.fsm       <= ST_INHIBIT;
      s_reg.poles     <= `POLES_RESET;
      s_reg.sel       <= `SEL_OFF;
      s_reg.rated_v   <= `RATED_V_RESET;
      s_reg.eff_poles <= `POLES_AUTO_NUM;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_waitrequest_out        = acc_w;
  assign avs_readdata_out           = s_reg.rdata;
  assign irq_out                    = |(s_reg.irq_stat & s_reg.irq_en);
  assign motor_cmd_out              = s_reg.cmd;
  assign nv_req_out                 = s_reg.nv;
  assign volt_limit_out             = s_reg.volt_lim;
  assign pole_count_out             = s_reg.eff_poles;
  assign drive_state_out            = s_reg.fsm;
  assign current_loop_prop_gain_out = s_reg.pgain[s_reg.set2];
  assign current_loop_int_gain_out  = s_reg.igain[s_reg.set2];

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  a_volt_limit_min: assert property (
    ##1 (volt_limit_out <= $past(headroom_volt_in)) && (volt_limit_out <= $past(s_reg.rated_v)))
    else $error("voltage limit above rated or headroom");
  a_auto_pole_six: assert property (
    (s_reg.poles == `POLES_AUTO) |=> (pole_count_out == `POLES_AUTO_NUM))
    else $error("auto pole code did not give six poles");
  a_start_needs_arm: assert property (
    (s_reg.fsm != ST_ALIGN) ##1 (s_reg.fsm == ST_ALIGN)
      |-> ($past(s_reg.sel) != `SEL_OFF) && $past(en_w) && $past(run_w))
    else $error("test started without selector, enable and run");
  a_dir_from_flag: assert property (
    (s_reg.fsm != ST_ALIGN) ##1 (s_reg.fsm == ST_ALIGN) |-> (motor_cmd_out.reverse == $past(s_reg.rev)))
    else $error("rotation direction does not follow reverse flag");
  a_no_start_stop: assert property (
    (s_reg.fsm == ST_STOP) |=> (s_reg.fsm != ST_ALIGN))
    else $error("test started from stop state");
  a_armed_no_stop: assert property (
    (s_reg.fsm != ST_STOP) ##1 (s_reg.fsm == ST_STOP) |-> ($past(s_reg.sel) == `SEL_OFF))
    else $error("stop state entered with selector armed");
  a_gains_only: assert property (
    (s_reg.fsm == ST_GAINS) |=> (s_reg.fsm == ST_INHIBIT) && !motor_cmd_out.energize && !nv_req_out.save)
    else $error("gain recompute ran a test");
  a_result_set: assert property (
    nv_req_out.save |-> (nv_req_out.set2 == s_reg.act_set2) && (s_reg.angle[s_reg.act_set2] == nv_req_out.data[15:0]))
    else $error("result written to wrong motor set");
  a_done_inhibit: assert property (
    (s_reg.fsm == ST_SETTLE) && motor_stopped_in && !trip_in && !tmo_w
      |=> (s_reg.fsm == ST_INHIBIT) && s_reg.lock && nv_req_out.save ##1 !motor_cmd_out.energize)
    else $error("completion did not save and inhibit");
  a_trip_no_save: assert property (
    (s_reg.fsm == ST_TRIP) |-> !nv_req_out.save && !motor_cmd_out.energize)
    else $error("store written after trip");
  a_card_mirror: assert property (
    nv_req_out.save |-> (nv_req_out.card == ((s_reg.card == `CARD_AUTO) || (s_reg.card == `CARD_BOOT))))
    else $error("card mirror mismatch");
  a_gain_guard: assert property (
    (s_reg.fsm == ST_GAINS) && !gains_ok_w |=> $stable(s_reg.pgain) && $stable(s_reg.igain))
    else $error("gains updated with zero resistance or inductance");
  a_two_revs: assert property (
    (s_reg.fsm == ST_ROTATE) ##1 (s_reg.fsm == ST_SETTLE) |-> ($past(s_reg.revs) == `TUNE_REVS_LAST) && $past(elec_rev_in))
    else $error("rotation ended before two revolutions");

  c_test_start: cover property ((s_reg.fsm == ST_INHIBIT) ##1 (s_reg.fsm == ST_ALIGN));
  c_test_done:  cover property (nv_req_out.save && nv_req_out.card);
  c_test_trip:  cover property ((s_reg.fsm == ST_ROTATE) ##1 (s_reg.fsm == ST_TRIP));
  c_gains_run:  cover property ((s_reg.fsm == ST_GAINS) && gains_ok_w);

endmodule : servo_autotune_sequencer

`default_nettype wire

// ===== servo_motor_model.sv
`timescale 1ns/1ps
`default_nettype none

module servo_motor_model
  import servo_tune_pkg::*;
#(
  parameter int REV_CYCLES = 12
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // drive side
  input  wire motor_cmd_s  cmd_in,
  input  wire logic        slow_in,
  // feedback
  output logic             stopped_out,
  output logic             elec_rev_out,
  output logic      [15:0] angle_out,
  output logic      [3:0]  revs_out
);
  logic [7:0] phase_reg;
  logic [3:0] coast_reg;

  // the rotor coasts a few cycles after torque is removed and the angle keeps drifting,
  // so an angle captured before rest comes out wrong
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      phase_reg    <= 8'h00;
      coast_reg    <= 4'h0;
      angle_out    <= 16'h1234;
      revs_out     <= 4'h0;
      elec_rev_out <= 1'b0;
    end else begin
      elec_rev_out <= 1'b0;
      if (cmd_in.rotate || coast_reg != 4'h0) begin
        angle_out <= cmd_in.reverse ? angle_out - 16'h0001 : angle_out + 16'h0001;
      end
      if (cmd_in.rotate) begin
        coast_reg <= 4'h6;
        if (int'(phase_reg) >= (slow_in ? 3 * REV_CYCLES : REV_CYCLES) - 1) begin
          phase_reg    <= 8'h00;
          elec_rev_out <= 1'b1;
          revs_out     <= revs_out + 4'h1;
        end else begin
          phase_reg <= phase_reg + 8'h01;
        end
      end else if (coast_reg != 4'h0) begin
        coast_reg <= coast_reg - 4'h1;
      end
      if (!cmd_in.energize) begin
        revs_out <= 4'h0;
      end
    end
  end

  assign stopped_out = (coast_reg == 4'h0) && !cmd_in.rotate;
endmodule : servo_motor_model

`default_nettype wire

// ===== servo_tune_params.svh
`ifndef SERVO_TUNE_PARAMS_SVH
`define SERVO_TUNE_PARAMS_SVH

// byte offsets on the register bus
`define AV_CTRL        8'h00
`define AV_POLES       8'h04
`define AV_SELECT      8'h08
`define AV_STATUS      8'h0C
`define AV_IRQ_STAT    8'h10
`define AV_IRQ_CLR     8'h14
`define AV_IRQ_EN      8'h18
`define AV_RATED_V     8'h1C
`define AV_SET_BASE    8'h40
`define AV_SET_MASK    8'hE0
`define AV_SET_BIT     4
`define SET_RES        2'h0
`define SET_IND        2'h1
`define SET_ANGLE      2'h2
`define SET_GAINS      2'h3

// control register fields
`define CTRL_SW_EN     0
`define CTRL_REV       1
`define CTRL_SET2      2
`define CTRL_CARD_HI   6
`define CTRL_CARD_LO   4

// reset values and codes
`define RATED_V_RESET  16'h0190
`define POLES_RESET    8'h03
`define POLES_AUTO     8'h00
`define POLES_MAX      8'h3C
`define POLES_AUTO_NUM 8'h06
`define SEL_OFF        8'h00
`define SEL_GAINS      8'h06
`define CARD_AUTO      3'h3
`define CARD_BOOT      3'h4
`define TUNE_REVS_LAST 2'h1
`define NV_ITEM_ANGLE  2'h0

// interrupt bits
`define IRQ_DONE       0
`define IRQ_FAIL       1
`define IRQ_GAIN_BLK   2
`define IRQ_REFUSED    3

// timing
`define CLK_KHZ        40000
`define TUNE_TIME_MS   2000
`define TUNE_CYCLES    (`TUNE_TIME_MS * `CLK_KHZ)

`endif

// ===== servo_tune_pkg.sv
package servo_tune_pkg;

  typedef enum logic [3:0] {
    ST_INHIBIT = 4'b0000,
    ST_STOP    = 4'b0001,
    ST_RUN     = 4'b0010,
    ST_ALIGN   = 4'b0011,
    ST_ROTATE  = 4'b0100,
    ST_SETTLE  = 4'b0101,
    ST_GAINS   = 4'b0110,
    ST_TRIP    = 4'b0111
  } tune_state_e;

  typedef struct packed {
    logic energize;
    logic rotate;
    logic reverse;
  } motor_cmd_s;

  typedef struct packed {
    logic        save;
    logic        card;
    logic        set2;
    logic [1:0]  item;
    logic [31:0] data;
  } nv_req_s;

  typedef struct packed {
    tune_state_e      fsm;
    logic             sw_en;
    logic             rev;
    logic             set2;
    logic [2:0]       card;
    logic [7:0]       poles;
    logic [7:0]       sel;
    logic [3:0]       irq_stat;
    logic [3:0]       irq_en;
    logic [15:0]      rated_v;
    logic [15:0]      volt_lim;
    logic [7:0]       eff_poles;
    logic [1:0][15:0] res;
    logic [1:0][15:0] ind;
    logic [1:0][15:0] angle;
    logic [1:0][15:0] pgain;
    logic [1:0][15:0] igain;
    logic [1:0]       revs;
    logic [26:0]      timer;
    logic             lock;
    logic             act_set2;
    logic             dir_rev;
    logic             ack;
    logic [31:0]      rdata;
    motor_cmd_s       cmd;
    nv_req_s          nv;
  } seq_state_s;

endpackage : servo_tune_pkg

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "servo_tune_params.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module tb_top;
  import servo_tune_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] m;} row_s;
  typedef struct packed {logic rev; logic set2; logic [2:0] card; logic slow; logic [1:0] off;} cfg_s;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        ref_clk_in, nrst_in, avs_read_in, avs_write_in, avs_waitrequest_out, irq_out;
  logic        enable_in, ctrl_word_enable_in, run_fwd_in, run_reverse_command_in;
  logic        motor_stopped_in, elec_rev_in, trip_in, slow;
  logic [7:0]  avs_address_in, pole_count_out;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic [15:0] encoder_angle_in, headroom_volt_in, volt_limit_out, last_angle;
  logic [15:0] current_loop_prop_gain_out, current_loop_int_gain_out;
  logic [3:0]  m_revs, last_revs;
  motor_cmd_s  motor_cmd_out;
  nv_req_s     nv_req_out, last_nv;
  tune_state_e drive_state_out;
  int          n_errors = 0, compares = 0, n_saves = 0, cycles = 0, n0;
  row_s rows [13] = '{
    '{1'b0, `AV_POLES, 32'h0000_0003, ALL}, '{1'b0, `AV_SELECT, 32'h0000_0000, ALL},
    '{1'b0, `AV_RATED_V, 32'h0000_0190, ALL}, '{1'b1, `AV_POLES, 32'h0000_0000, ALL},
    '{1'b0, `AV_STATUS, 32'h0000_0006, 32'h0000_00FF}, '{1'b1, `AV_POLES, 32'h0000_003D, ALL},
    '{1'b0, `AV_POLES, 32'h0000_0000, ALL}, '{1'b1, `AV_POLES, 32'h0000_003C, ALL},
    '{1'b0, `AV_STATUS, 32'h0000_0078, 32'h0000_00FF}, '{1'b1, `AV_SELECT, 32'h0000_0007, ALL},
    '{1'b0, `AV_SELECT, 32'h0000_0000, ALL}, '{1'b0, 8'h20, 32'h0000_0000, ALL},
    '{1'b0, `AV_IRQ_CLR, 32'h0000_0000, ALL}};
  cfg_s cfgs [5] = '{'{1'b1, 1'b0, 3'h3, 1'b0, 2'h0}, '{1'b0, 1'b1, 3'h4, 1'b1, 2'h1},
    '{1'b0, 1'b0, 3'h0, 1'b0, 2'h2}, '{1'b1, 1'b1, 3'h2, 1'b0, 2'h0}, '{1'b0, 1'b0, 3'h3, 1'b1, 2'h0}};

  servo_autotune_sequencer #(.TUNE_CYCLES(400)) uut (.ref_clk_in, .nrst_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .irq_out, .enable_in,
    .ctrl_word_enable_in, .run_fwd_in, .run_reverse_command_in, .motor_stopped_in, .elec_rev_in,
    .encoder_angle_in, .trip_in, .headroom_volt_in, .motor_cmd_out, .nv_req_out, .volt_limit_out,
    .pole_count_out, .drive_state_out, .current_loop_prop_gain_out, .current_loop_int_gain_out);
  servo_motor_model m0 (.clk_in(ref_clk_in), .nrst_in(nrst_in), .cmd_in(motor_cmd_out), .slow_in(slow),
    .stopped_out(motor_stopped_in), .elec_rev_out(elec_rev_in), .angle_out(encoder_angle_in), .revs_out(m_revs));

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  // save pulses last one cycle, so they are caught here rather than by polling
  always @(posedge ref_clk_in) begin
    cycles++;
    if (nv_req_out.save === 1'b1) begin
      n_saves++;
      last_nv = nv_req_out;
      last_revs = m_revs;
      last_angle = encoder_angle_in;
    end
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task test_done;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // entered just after a rising edge; two idle edges let a write's registered effects settle
  task av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
  endtask : av

  task wait_state(input tune_state_e s);
    int k;
    for (k = 0; k < 3000 && drive_state_out !== s; k++) @(posedge ref_clk_in);
    `CHK("state", s, drive_state_out)
  endtask : wait_state

  initial begin
    nrst_in = 1'b0; avs_read_in = 1'b0; avs_write_in = 1'b0; avs_address_in = 8'h00;
    avs_writedata_in = 32'h0000_0000; enable_in = 1'b0; ctrl_word_enable_in = 1'b1; run_fwd_in = 1'b0;
    run_reverse_command_in = 1'b0; trip_in = 1'b0; headroom_volt_in = 16'h0100; slow = 1'b0;
    repeat (3) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    @(posedge ref_clk_in);
    `CHK("poles", 8'h06, pole_count_out)
    `CHK("irq", 1'b0, irq_out)
    foreach (rows[i]) begin
      av(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) `CHK("reg", rows[i].d & rows[i].m, rd & rows[i].m)
    end
    `CHK("poles", 8'h78, pole_count_out)
    `CHK("vlim", 16'h0100, volt_limit_out)
    headroom_volt_in <= 16'h0300;
    repeat (3) @(posedge ref_clk_in);
    `CHK("vlim", 16'h0190, volt_limit_out)
    av(1'b1, `AV_RATED_V, 32'h0000_0080);
    `CHK("vlim", 16'h0080, volt_limit_out)
    // gains only: drive stays disabled throughout
    av(1'b1, `AV_SET_BASE, 32'h0000_0011);
    av(1'b1, `AV_SET_BASE + 8'h04, 32'h0000_0022);
    av(1'b1, `AV_SELECT, 32'h0000_0006);
    av(1'b0, `AV_SET_BASE + 8'h0C, 32'h0000_0000);
    `CHK("gains", 32'h0011_0022, rd)
    `CHK("pgain", 16'h0022, current_loop_prop_gain_out)
    `CHK("igain", 16'h0011, current_loop_int_gain_out)
    av(1'b0, `AV_SELECT, 32'h0000_0000);
    `CHK("sel", 32'h0000_0000, rd)
    av(1'b1, `AV_IRQ_EN, 32'h0000_0004);
    av(1'b1, `AV_CTRL, 32'h0000_0004);
    av(1'b1, `AV_SET_BASE + 8'h14, 32'h0000_0055);
    av(1'b1, `AV_SELECT, 32'h0000_0006);
    av(1'b0, `AV_SET_BASE + 8'h1C, 32'h0000_0000);
    `CHK("gains2", 32'h0000_0000, rd)
    `CHK("irq", 1'b1, irq_out)
    av(1'b1, `AV_IRQ_EN, 32'h0000_0000);
    `CHK("irqmask", 1'b0, irq_out)
    av(1'b1, `AV_IRQ_EN, 32'h0000_0004);
    av(1'b1, `AV_IRQ_CLR, 32'h0000_0004);
    `CHK("irqclr", 1'b0, irq_out)
    // armed selector with enable but no run must not reach stop
    av(1'b1, `AV_CTRL, 32'h0000_0001);
    av(1'b1, `AV_SELECT, 32'h0000_0001);
    enable_in <= 1'b1;
    repeat (5) @(posedge ref_clk_in);
    `CHK("state", ST_INHIBIT, drive_state_out)
    enable_in <= 1'b0;
    av(1'b1, `AV_SELECT, 32'h0000_0000);
    enable_in <= 1'b1;
    wait_state(ST_STOP);
    n0 = n_saves;
    av(1'b1, `AV_SELECT, 32'h0000_0001);
    run_fwd_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    `CHK("start", 1'b0, drive_state_out == ST_ALIGN)
    av(1'b0, `AV_IRQ_STAT, 32'h0000_0000);
    `CHK("refused", 1'b1, rd[3])
    av(1'b1, `AV_SELECT, 32'h0000_0000);
    `CHK("state", ST_RUN, drive_state_out)
    run_fwd_in <= 1'b0;
    enable_in <= 1'b0;
    wait_state(ST_INHIBIT);
    foreach (cfgs[i]) begin
      av(1'b1, `AV_CTRL, {25'h0, cfgs[i].card, 1'b0, cfgs[i].set2, cfgs[i].rev, 1'b1});
      av(1'b1, `AV_SELECT, 32'(i + 1));
      slow <= cfgs[i].slow;
      enable_in <= 1'b1;
      run_reverse_command_in <= cfgs[i].slow;
      run_fwd_in <= !cfgs[i].slow;
      n0 = n_saves;
      wait_state(ST_ALIGN);
      wait_state(ST_ROTATE);
      `CHK("dir", cfgs[i].rev, motor_cmd_out.reverse)
      wait_state(ST_INHIBIT);
      @(posedge ref_clk_in);
      `CHK("saves", n0 + 1, n_saves)
      `CHK("revs", 4'h2, last_revs)
      `CHK("angle", last_angle, last_nv.data[15:0])
      `CHK("set2", cfgs[i].set2, last_nv.set2)
      `CHK("item", `NV_ITEM_ANGLE, last_nv.item)
      `CHK("card", cfgs[i].card == 3'h3 || cfgs[i].card == 3'h4, last_nv.card)
      `CHK("energ", 1'b0, motor_cmd_out.energize)
      repeat (4) @(posedge ref_clk_in);
      `CHK("lock", ST_INHIBIT, drive_state_out)
      case (cfgs[i].off)
        2'h0: enable_in <= 1'b0;
        2'h1: av(1'b1, `AV_CTRL, 32'h0000_0000);
        default: ctrl_word_enable_in <= 1'b0;
      endcase
      run_fwd_in <= 1'b0;
      run_reverse_command_in <= 1'b0;
      @(posedge ref_clk_in);
      av(1'b0, `AV_STATUS, 32'h0000_0000);
      `CHK("unlock", 1'b0, rd[11])
      ctrl_word_enable_in <= 1'b1;
      enable_in <= 1'b0;
    end
    av(1'b1, `AV_POLES, 32'h0000_0005);
    `CHK("poles", 8'h0A, pole_count_out)
    // a failing step must stop all further saving
    av(1'b1, `AV_CTRL, 32'h0000_0001);
    av(1'b1, `AV_SELECT, 32'h0000_0001);
    enable_in <= 1'b1;
    run_fwd_in <= 1'b1;
    n0 = n_saves;
    wait_state(ST_ROTATE);
    trip_in <= 1'b1;
    wait_state(ST_TRIP);
    trip_in <= 1'b0;
    repeat (60) @(posedge ref_clk_in);
    `CHK("saves", n0, n_saves)
    av(1'b0, `AV_IRQ_STAT, 32'h0000_0000);
    `CHK("fail", 1'b1, rd[1])
    enable_in <= 1'b0;
    run_fwd_in <= 1'b0;
    wait_state(ST_INHIBIT);
    av(1'b0, `AV_SELECT, 32'h0000_0000);
    `CHK("sel", 32'h0000_0000, rd)
    test_done();
  end
endmodule : tb_top

`default_nettype wire
